// ===== inc/cce_pkg.sv
// shared constants and carrier types for the counter command executor
package cce_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int CCE_NUM_CTR = 5;
  localparam int CCE_CW      = 16;
  localparam int CCE_CMD_W   = 8;

  // ****************************************
  // command code layout
  // ****************************************
  localparam int CCE_OP_HI  = 7;
  localparam int CCE_OP_LO  = 5;
  localparam int CCE_SUB_HI = 4;
  localparam int CCE_SUB_LO = 3;
  localparam int CCE_NUM_HI = 2;
  localparam int CCE_NUM_LO = 0;
  localparam int CCE_SEL_HI = 4;
  localparam int CCE_SEL_LO = 0;

  // upper three code bits
  localparam logic [2:0] CCE_OP_ARM      = 3'h1;
  localparam logic [2:0] CCE_OP_LOAD     = 3'h2;
  localparam logic [2:0] CCE_OP_LOAD_ARM = 3'h3;
  localparam logic [2:0] CCE_OP_DIS_SAVE = 3'h4;
  localparam logic [2:0] CCE_OP_SAVE     = 3'h5;
  localparam logic [2:0] CCE_OP_DISARM   = 3'h6;
  localparam logic [2:0] CCE_OP_MISC     = 3'h7;

  // two bits below the op field for the single-counter group
  localparam logic [1:0] CCE_SUB_CLR_TOG = 2'h0;
  localparam logic [1:0] CCE_SUB_SET_TOG = 2'h1;
  localparam logic [1:0] CCE_SUB_STEP    = 2'h2;

  // counter numbers 1..5 in the three-bit field
  localparam logic [2:0] CCE_NUM_FIRST = 3'h1;
  localparam logic [2:0] CCE_NUM_LAST  = 3'h5;

  // ****************************************
  // output control field codes
  // ****************************************
  localparam logic [2:0] CCE_OCF_TC_HIGH = 3'h1;
  localparam logic [2:0] CCE_OCF_TOGGLE  = 3'h2;

  // ****************************************
  // count values
  // ****************************************
  localparam logic [CCE_CW-1:0] CCE_ONE      = 16'h0001;
  localparam logic [CCE_CW-1:0] CCE_ALL_ONES = 16'hFFFF;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic       alt_reload;      // reload source alternates hold/load
    logic       gate_reload;     // gate level picks the reload source
    logic       disarm_on_tc;    // counter disarms itself at terminal count
    logic       count_direction_bit;
    logic [2:0] output_control_field;
  } cce_cfg_type;

  typedef struct packed {
    logic [CCE_NUM_CTR-1:0] arm;
    logic [CCE_NUM_CTR-1:0] load;
    logic [CCE_NUM_CTR-1:0] load_arm;
    logic [CCE_NUM_CTR-1:0] disarm;
    logic [CCE_NUM_CTR-1:0] save;
    logic [CCE_NUM_CTR-1:0] set_tog;
    logic [CCE_NUM_CTR-1:0] clr_tog;
    logic [CCE_NUM_CTR-1:0] step;
  } cce_cmd_type;

  typedef struct packed {
    logic [CCE_CW-1:0] value;
    logic [CCE_CW-1:0] hold;
    logic              armed;
    logic              terminal_count;
    logic              disarm_pend;
    logic              sel_hold;       // upcoming tc reloads from hold
    logic              toggle;
    logic              out;
  } cce_ctr_type;

  typedef struct packed {
    cce_ctr_type [CCE_NUM_CTR-1:0] ctr;
  } cce_state_type;

endpackage

// ===== core/cce_cmd_decode.sv
// command code decoder: one 8-bit code into per-counter operation masks
`timescale 1ns/10ps
module cce_cmd_decode
  import cce_pkg::*;
(
  input  wire logic                 cmd_valid,
  input  wire logic [CCE_CMD_W-1:0] cmd_code,
  output cce_cmd_type               cmd
);

  // ****************************************
  // counter number to one-hot
  // ****************************************
  // numbers outside 1..5 select nothing, so the master-mode codes sharing this group fall through
  function automatic logic [CCE_NUM_CTR-1:0] num_onehot(input logic [2:0] n);
    logic [CCE_NUM_CTR-1:0] r;
    r = '0;
    if (n >= CCE_NUM_FIRST && n <= CCE_NUM_LAST)
    begin
      r[n - CCE_NUM_FIRST] = 1'b1;
    end
    return r;
  endfunction

  logic [2:0]             op;
  logic [1:0]             sub;
  logic [CCE_NUM_CTR-1:0] sel;
  logic [CCE_NUM_CTR-1:0] one;

  // field split
  assign op  = cmd_code[CCE_OP_HI:CCE_OP_LO];
  assign sub = cmd_code[CCE_SUB_HI:CCE_SUB_LO];
  assign sel = cmd_code[CCE_SEL_HI:CCE_SEL_LO];
  assign one = num_onehot(cmd_code[CCE_NUM_HI:CCE_NUM_LO]);

  // op decode; codes not owned by this block decode to no action
  always_comb
  begin
    cmd = '0;
    if (cmd_valid)
    begin
      unique case (op)
        CCE_OP_ARM:      cmd.arm      = sel;
        CCE_OP_LOAD:     cmd.load     = sel;
        CCE_OP_LOAD_ARM: cmd.load_arm = sel;
        CCE_OP_DIS_SAVE:
        begin
          cmd.disarm = sel;
          cmd.save   = sel;
        end
        CCE_OP_SAVE:     cmd.save     = sel;
        CCE_OP_DISARM:   cmd.disarm   = sel;
        CCE_OP_MISC:
        begin
          if (sub == CCE_SUB_SET_TOG)
          begin
            cmd.set_tog = one;
          end
          else if (sub == CCE_SUB_CLR_TOG)
          begin
            cmd.clr_tog = one;
          end
          else if (sub == CCE_SUB_STEP)
          begin
            cmd.step = one;
          end
        end
        default: cmd = '0;  // data pointer group is handled elsewhere
      endcase
    end
  end

endmodule

// ===== core/cce_counter_exec.sv
// five-counter command executor: arm, load, save, disarm, toggle and step
`timescale 1ns/10ps
// Operation
// - select bit n acts on counter n
// - arm enables counting; unarmed never counts
// - arm never disarms unselected counters
// - gating still suspends an armed counter
// - disarm in terminal count waits for exit
// - arm resets alternating reload selector to hold
// - load copies load or hold, sources kept
// - load before terminal count enters it
// - load during terminal count ends it
// - load source by arm state and mode
// - load-made terminal count toggles selector
// - load in terminal count never toggles selector
// - load-and-arm is load then arm
// - load-and-arm makes next alternating reload from hold
// - disarm stops all counting, except exit
// - save copies count into hold register
// - disarm-and-save equals disarm then save
// - set or clear toggle of counter n
// - toggle reaches pin only in toggle mode
// - step moves count by one per direction
// - step works on disarmed counter
module cce_counter_exec
  import cce_pkg::*;
#(
  parameter int NUM_CTR     = CCE_NUM_CTR,
  parameter int COUNT_WIDTH = CCE_CW
)
(
  input  wire logic                                 mclk,
  input  wire logic                                 rst,
  input  wire logic                                 cmd_valid,
  input  wire logic [CCE_CMD_W-1:0]                 cmd_code,
  input  cce_cfg_type [CCE_NUM_CTR-1:0]             cfg,
  input  wire logic [CCE_NUM_CTR-1:0]               count_edge,
  input  wire logic [CCE_NUM_CTR-1:0]               gate_ok,
  input  wire logic [CCE_NUM_CTR-1:0]               gate_level,
  input  wire logic [CCE_NUM_CTR-1:0][CCE_CW-1:0]   load_data,
  input  wire logic [CCE_NUM_CTR-1:0]               hold_wr,
  input  wire logic [CCE_CW-1:0]                    hold_wr_data,
  output logic      [CCE_NUM_CTR-1:0][CCE_CW-1:0]   counter_value,
  output logic      [CCE_NUM_CTR-1:0][CCE_CW-1:0]   hold_value,
  output logic      [CCE_NUM_CTR-1:0]               armed,
  output logic      [CCE_NUM_CTR-1:0]               terminal_count,
  output logic      [CCE_NUM_CTR-1:0]               disarm_pending,
  output logic      [CCE_NUM_CTR-1:0]               toggle_state,
  output logic      [CCE_NUM_CTR-1:0]               counter_out
);

  // ****************************************
  // elaboration checks
  // ****************************************
  // the select field and state layout are fixed at five counters of sixteen bits
  if (NUM_CTR != CCE_NUM_CTR)
  begin : g_bad_num
    $error("cce_counter_exec: NUM_CTR must equal five");
  end
  if (COUNT_WIDTH != CCE_CW)
  begin : g_bad_width
    $error("cce_counter_exec: COUNT_WIDTH must equal sixteen");
  end

  // ****************************************
  // helpers
  // ****************************************
  // true when the next count lands on terminal count
  function automatic logic at_pre_tc(input logic [CCE_CW-1:0] v, input logic up);
    return up ? (v == CCE_ALL_ONES) : (v == CCE_ONE);
  endfunction

  // one count in the configured direction, wraps by design
  function automatic logic [CCE_CW-1:0] step_val(input logic [CCE_CW-1:0] v, input logic up);
    return up ? CCE_CW'(v + CCE_ONE) : CCE_CW'(v - CCE_ONE);
  endfunction

  // reload source for a terminal count: 1 = hold, 0 = load
  function automatic logic tc_src(input cce_ctr_type c, input cce_cfg_type f, input logic g);
    if (f.gate_reload)
    begin
      return g;
    end
    return f.alt_reload & c.sel_hold;
  endfunction

  // one count pulse, from a source edge, a step or a load before terminal count
  function automatic cce_ctr_type advance(input cce_ctr_type c, input cce_cfg_type f,
                                          input logic [CCE_CW-1:0] ld, input logic g);
    cce_ctr_type r;
    r = c;
    if (at_pre_tc(c.value, f.count_direction_bit))
    begin
      r.value          = tc_src(c, f, g) ? c.hold : ld;
      r.terminal_count = 1'b1;
      r.toggle         = ~c.toggle;
      if (f.alt_reload)
      begin
        r.sel_hold = ~c.sel_hold;
      end
      if (f.disarm_on_tc)
      begin
        r.armed = 1'b0;
      end
    end
    else
    begin
      r.value          = step_val(c.value, f.count_direction_bit);
      r.terminal_count = 1'b0;
      if (c.terminal_count && c.disarm_pend)
      begin
        r.armed       = 1'b0;
        r.disarm_pend = 1'b0;
      end
    end
    return r;
  endfunction

  // ****************************************
  // command decode
  // ****************************************
  cce_cmd_type cmd;

  cce_cmd_decode u_decode
  (
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code),
    .cmd       (cmd)
  );

  // ****************************************
  // state
  // ****************************************
  cce_state_type          s_reg;
  cce_state_type          s_next;
  logic [CCE_NUM_CTR-1:0] count_evt;

  always_comb
  begin
    for (int i = 0; i < CCE_NUM_CTR; i++)
    begin
      count_evt[i] = s_reg.ctr[i].armed & gate_ok[i] & count_edge[i];
    end
  end

  // next state: count pulse first, then command; all counters in the same pass
  // same-cycle multi-counter update
  always_comb
  begin
    cce_ctr_type c;
    cce_ctr_type r;
    cce_cfg_type f;
    logic        ld_src;
    c      = '0;
    r      = '0;
    f      = '0;
    ld_src = 1'b0;
    s_next = s_reg;
    for (int i = 0; i < CCE_NUM_CTR; i++)
    begin
      c = s_reg.ctr[i];
      f = cfg[i];
      r = c;

      // only armed counters count; step ignores arm
      if (count_evt[i] || cmd.step[i])
      begin
        r = advance(r, f, load_data[i], gate_level[i]);
      end

      if (cmd.load[i] || cmd.load_arm[i])
      begin
        if (f.gate_reload)
        begin
          ld_src = gate_level[i];
        end
        else
        begin
          ld_src = r.armed & f.alt_reload & r.sel_hold;
        end
        if (r.terminal_count)
        begin
          r.value          = ld_src ? r.hold : load_data[i];
          r.terminal_count = 1'b0;
          if (r.disarm_pend)
          begin
            r.armed       = 1'b0;
            r.disarm_pend = 1'b0;
          end
        end
        else if (at_pre_tc(r.value, f.count_direction_bit))
        begin
          r = advance(r, f, load_data[i], gate_level[i]);
        end
        else
        begin
          r.value = ld_src ? r.hold : load_data[i];
        end
      end

      // arm only sets; arm part of load-and-arm
      if (cmd.arm[i] || cmd.load_arm[i])
      begin
        r.armed       = 1'b1;
        r.disarm_pend = 1'b0;
        if (f.alt_reload)
        begin
          r.sel_hold = 1'b1;
        end
      end

      if (cmd.disarm[i])
      begin
        if (r.terminal_count)
        begin
          r.disarm_pend = 1'b1;
        end
        else
        begin
          r.armed = 1'b0;
        end
      end

      // host write to hold; a save in the same cycle wins
      if (hold_wr[i])
      begin
        r.hold = hold_wr_data;
      end
      if (cmd.save[i])
      begin
        r.hold = c.value;
      end

      if (cmd.set_tog[i])
      begin
        r.toggle = 1'b1;
      end
      else if (cmd.clr_tog[i])
      begin
        r.toggle = 1'b0;
      end

      // pin sees toggle only in toggle mode
      if (f.output_control_field == CCE_OCF_TOGGLE)
      begin
        r.out = r.toggle;
      end
      else if (f.output_control_field == CCE_OCF_TC_HIGH)
      begin
        r.out = r.terminal_count;
      end
      else
      begin
        r.out = 1'b0;
      end

      s_next.ctr[i] = r;
    end
  end

  // state register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // all outputs come straight from the state flops
  always_comb
  begin
    for (int i = 0; i < CCE_NUM_CTR; i++)
    begin
      counter_value[i]  = s_reg.ctr[i].value;
      hold_value[i]     = s_reg.ctr[i].hold;
      armed[i]          = s_reg.ctr[i].armed;
      terminal_count[i] = s_reg.ctr[i].terminal_count;
      disarm_pending[i] = s_reg.ctr[i].disarm_pend;
      toggle_state[i]   = s_reg.ctr[i].toggle;
      counter_out[i]    = s_reg.ctr[i].out;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  for (genvar g = 0; g < CCE_NUM_CTR; g++)
  begin : g_chk
    a_arm_enables:
      assert property (cmd.arm[g] |=> armed[g])
      else $error("armed counter did not arm");

    // no movement without arm, step or load
    a_no_unarmed_count:
      assert property (!armed[g] && !cmd.step[g] && !cmd.load[g] && !cmd.load_arm[g]
                       |=> $stable(counter_value[g]))
      else $error("unarmed counter moved");

    a_arm_keeps_armed:
      assert property (armed[g] && !cmd.disarm[g] && !disarm_pending[g] && !cfg[g].disarm_on_tc
                       |=> armed[g])
      else $error("counter lost arm without disarm");

    a_disarm_deferred:
      assert property (cmd.disarm[g] && terminal_count[g] && !count_evt[g] && !cmd.step[g]
                       && !cmd.load[g] && !cmd.load_arm[g] |=> armed[g] == $past(armed[g]) && disarm_pending[g])
      else $error("disarm in tc not deferred");

    a_load_ends_tc:
      assert property (cmd.load[g] && terminal_count[g] && !count_evt[g] && !cmd.step[g]
                       |=> !terminal_count[g])
      else $error("load did not end tc");

    a_save_copies:
      assert property (cmd.save[g] |=> hold_value[g] == $past(counter_value[g]))
      else $error("save did not copy count");

    a_step_down_one:
      assert property (cmd.step[g] && !cfg[g].count_direction_bit && !count_evt[g]
                       && !cmd.load[g] && !cmd.load_arm[g] && counter_value[g] != CCE_ONE
                       |=> counter_value[g] == CCE_CW'($past(counter_value[g]) - CCE_ONE))
      else $error("step did not decrement by one");

    a_toggle_set:
      assert property (cmd.set_tog[g] |=> toggle_state[g] ##1 (toggle_state[g] || terminal_count[g]
                       || $past(cmd.clr_tog[g])))
      else $error("set toggle failed");

    // toggle mode shows the toggle flop
    a_out_toggle:
      assert property (cfg[g].output_control_field == CCE_OCF_TOGGLE
                       |=> $past(cfg[g].output_control_field) != CCE_OCF_TOGGLE || counter_out[g] == toggle_state[g])
      else $error("toggle not on output");

    // load-and-arm points next tc at hold
    a_larm_hold:
      assert property (cmd.load_arm[g] && cfg[g].alt_reload |=> s_reg.ctr[g].sel_hold)
      else $error("load-and-arm did not select hold");
  end

  a_sync_arm:
    assert property (cmd.arm == 5'h1F |=> &armed)
    else $error("multi-counter arm not simultaneous");

endmodule

// ===== verification/cce_host_model.sv
// host processor model: writes command codes into the executor
`timescale 1ns/10ps
module cce_host_model
  import cce_pkg::*;
(
  input  wire logic                 mclk,
  output logic                      cmd_valid,
  output logic [CCE_CMD_W-1:0]      cmd_code
);
  // ****************************************
  // command port
  // ****************************************
  // idle state at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
  end

  // a released code is inverted so a stale value never lingers
  // defined codes, synchronous use
  task automatic issue(input logic [CCE_CMD_W-1:0] code);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_code  = code;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
  endtask
endmodule

// ===== verification/testbench.sv
// self-checking bench for the counter command executor
`timescale 1ns/10ps
module testbench
  import cce_pkg::*;
;
  // ****************************************
  // signals
  // ****************************************
  logic                               mclk = 1'b0;
  logic                               rst  = 1'b1;
  logic                               cmd_valid;
  logic [CCE_CMD_W-1:0]               cmd_code;
  cce_cfg_type [CCE_NUM_CTR-1:0]      cfg = '0;
  logic [CCE_NUM_CTR-1:0]             count_edge = '0;
  logic [CCE_NUM_CTR-1:0]             gate_ok = 5'h1F;
  logic [CCE_NUM_CTR-1:0]             gate_level = '0;
  logic [CCE_NUM_CTR-1:0][CCE_CW-1:0] load_data;
  logic [CCE_NUM_CTR-1:0]             hold_wr = '0;
  logic [CCE_CW-1:0]                  hold_wr_data = '0;
  logic [CCE_NUM_CTR-1:0][CCE_CW-1:0] counter_value;
  logic [CCE_NUM_CTR-1:0][CCE_CW-1:0] hold_value;
  logic [CCE_NUM_CTR-1:0]             armed;
  logic [CCE_NUM_CTR-1:0]             terminal_count;
  logic [CCE_NUM_CTR-1:0]             disarm_pending;
  logic [CCE_NUM_CTR-1:0]             toggle_state;
  logic [CCE_NUM_CTR-1:0]             counter_out;
  int                                 n_mismatch = 0;
  int                                 num_checks = 0;

  // 4 ns period
  always #2 mclk = ~mclk;

  cce_host_model i_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code));

  cce_counter_exec i_dut (
    .mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cfg(cfg),
    .count_edge(count_edge), .gate_ok(gate_ok), .gate_level(gate_level), .load_data(load_data),
    .hold_wr(hold_wr), .hold_wr_data(hold_wr_data), .counter_value(counter_value),
    .hold_value(hold_value), .armed(armed), .terminal_count(terminal_count),
    .disarm_pending(disarm_pending), .toggle_state(toggle_state), .counter_out(counter_out));

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [CCE_CW-1:0] seen, input logic [CCE_CW-1:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // count and terminal-count state of one counter
  task automatic cv(input int i, input logic [CCE_CW-1:0] v, input logic tc, input string what);
    check(counter_value[i], v, what);
    check(CCE_CW'(terminal_count[i]), CCE_CW'(tc), what);
  endtask

  // one-cycle count-source pulse, driven just after the edge
  task automatic pulse(input logic [CCE_NUM_CTR-1:0] m);
    @(posedge mclk);
    #1;
    count_edge = m;
    @(posedge mclk);
    #1;
    count_edge = '0;
  endtask

  // host write straight into the selected hold registers
  task automatic hwr(input logic [CCE_NUM_CTR-1:0] m, input logic [CCE_CW-1:0] d);
    @(posedge mclk);
    #1;
    hold_wr      = m;
    hold_wr_data = d;
    @(posedge mclk);
    #1;
    hold_wr      = '0;
    hold_wr_data = ~d;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    check(CCE_CW'(armed | terminal_count | toggle_state | counter_out), '0, "reset flags");
    check(counter_value[0] | hold_value[4], '0, "reset values");
    $display("test reset done");
  endtask

  task automatic t_arm();
    i_host.issue(8'h5F);
    for (int i = 0; i < CCE_NUM_CTR; i++)
    begin
      check(counter_value[i], load_data[i], "load all");
      check(hold_value[i], '0, "sources kept");
    end
    i_host.issue(8'h25);
    check(CCE_CW'(armed), 16'h0005, "arm 1 and 3");
    pulse(5'h1F);
    check(counter_value[0], 16'h00FF, "armed counts");
    check(counter_value[1], 16'h0101, "unarmed idle");
    check(counter_value[2], 16'h0101, "same edge");
    i_host.issue(8'h22);
    check(CCE_CW'(armed), 16'h0007, "arm keeps others");
    gate_ok = 5'h1E;
    pulse(5'h1F);
    check(counter_value[0], 16'h00FF, "gated off");
    check(counter_value[1], 16'h0100, "gated on");
    gate_ok = 5'h1F;
    $display("test arm done");
  endtask

  task automatic t_save();
    i_host.issue(8'hA1);
    check(hold_value[0], 16'h00FF, "save");
    pulse(5'h01);
    check(counter_value[0], 16'h00FE, "save keeps counting");
    i_host.issue(8'hC2);
    check(CCE_CW'(armed), 16'h0005, "disarm");
    i_host.issue(8'h84);
    check(CCE_CW'(armed), 16'h0001, "disarm and save");
    check(hold_value[2], 16'h0100, "disarm and save");
    pulse(5'h1F);
    check(counter_value[1], 16'h0100, "disarmed idle");
    check(counter_value[0], 16'h00FD, "armed counts");
    $display("test save done");
  endtask

  task automatic t_toggle();
    logic [CCE_NUM_CTR-1:0] exp;
    exp = '0;
    for (int i = 0; i < CCE_NUM_CTR; i++)
      cfg[i].output_control_field = (i % 2 == 0) ? CCE_OCF_TOGGLE : 3'h0;
    for (int n = 1; n <= CCE_NUM_CTR; n++)
    begin
      i_host.issue({CCE_OP_MISC, CCE_SUB_SET_TOG, 3'(n)});
      exp[n-1] = 1'b1;
      check(CCE_CW'(toggle_state), CCE_CW'(exp), "set toggle");
    end
    @(posedge mclk);
    #1;
    check(CCE_CW'(counter_out), 16'h0015, "toggle pin");
    for (int n = 1; n <= CCE_NUM_CTR; n++)
    begin
      i_host.issue({CCE_OP_MISC, CCE_SUB_CLR_TOG, 3'(n)});
      exp[n-1] = 1'b0;
      check(CCE_CW'(toggle_state), CCE_CW'(exp), "clear toggle");
    end
    for (int i = 0; i < CCE_NUM_CTR; i++)
      cfg[i].output_control_field = 3'h0;
    $display("test toggle done");
  endtask

  task automatic t_step();
    i_host.issue(8'hF4);
    check(counter_value[3], 16'h0102, "step down disarmed");
    cfg[4].count_direction_bit = 1'b1;
    i_host.issue(8'hF5);
    check(counter_value[4], 16'h0105, "step up");
    $display("test step done");
  endtask

  task automatic t_tc_disarm();
    load_data[0] = 16'h0001;
    i_host.issue(8'h41);
    cv(0, 16'h0001, 1'b0, "load armed");
    load_data[0] = 16'h0007;
    i_host.issue(8'h41);
    cv(0, 16'h0007, 1'b1, "load before tc");
    i_host.issue(8'hC1);
    check(CCE_CW'({armed[0], disarm_pending[0]}), 16'h0003, "disarm deferred");
    pulse(5'h01);
    cv(0, 16'h0006, 1'b0, "exit count");
    pulse(5'h01);
    cv(0, 16'h0006, 1'b0, "disarmed after exit");
    check(CCE_CW'({armed[0], disarm_pending[0]}), '0, "disarm done");
    $display("test tc disarm done");
  endtask

  task automatic t_alt();
    cfg[1].alt_reload = 1'b1;
    load_data[1] = 16'h0002;
    hwr(5'h02, 16'h00A0);
    i_host.issue(8'h62);
    cv(1, 16'h0002, 1'b0, "load and arm");
    pulse(5'h02);
    pulse(5'h02);
    cv(1, 16'h00A0, 1'b1, "first tc from hold");
    i_host.issue(8'h42);
    cv(1, 16'h0002, 1'b0, "load ends tc");
    pulse(5'h02);
    pulse(5'h02);
    cv(1, 16'h0002, 1'b1, "second tc from load");
    pulse(5'h02);
    i_host.issue(8'h42);
    cv(1, 16'h00A0, 1'b1, "load made tc");
    i_host.issue(8'h62);
    cv(1, 16'h0002, 1'b0, "load and arm in tc");
    pulse(5'h02);
    pulse(5'h02);
    cv(1, 16'h00A0, 1'b1, "next tc from hold");
    $display("test alternate done");
  endtask

  task automatic t_gate_src();
    cfg[3].gate_reload = 1'b1;
    gate_level[3] = 1'b1;
    hwr(5'h08, 16'h0055);
    i_host.issue(8'h48);
    cv(3, 16'h0055, 1'b0, "gate picks hold");
    gate_level[3] = 1'b0;
    i_host.issue(8'h48);
    cv(3, load_data[3], 1'b0, "gate picks load");
    $display("test gate source done");
  endtask

  task automatic t_retrig();
    cfg[4].count_direction_bit = 1'b0;
    cfg[4].disarm_on_tc = 1'b1;
    load_data[4] = 16'h0001;
    i_host.issue(8'h50);
    i_host.issue(8'h30);
    pulse(5'h10);
    cv(4, 16'h0001, 1'b1, "tc reached");
    i_host.issue(8'h70);
    check(CCE_CW'(armed[4]), 16'h0001, "rearmed");
    pulse(5'h10);
    cv(4, 16'h0001, 1'b1, "counts again");
    $display("test retrigger done");
  endtask

  // every counter in one mode: gate-picked reload, up count, disarm at tc, tc shown on the pin
  task automatic t_wide();
    for (int i = 0; i < CCE_NUM_CTR; i++)
      cfg[i] = '{alt_reload: 1'b0, gate_reload: 1'b1, disarm_on_tc: 1'b1, count_direction_bit: 1'b1,
                 output_control_field: CCE_OCF_TC_HIGH};
    hwr(5'h1F, 16'hFFF0);
    gate_level = 5'h1F;
    i_host.issue(8'h5F);
    for (int i = 0; i < CCE_NUM_CTR; i++)
      cv(i, 16'hFFF0, 1'b0, "all gates pick hold");
    gate_level = '0;
    for (int i = 0; i < CCE_NUM_CTR; i++)
      load_data[i] = 16'hFFFE;
    i_host.issue(8'h5F);
    check(counter_value[4], 16'hFFFE, "all gates pick load");
    i_host.issue(8'h3F);
    check(CCE_CW'(armed), 16'h001F, "arm all");
    gate_ok = '0;
    pulse(5'h1F);
    check(counter_value[2], 16'hFFFE, "all gated off");
    gate_ok = 5'h1F;
    pulse(5'h1F);
    check(counter_value[0], 16'hFFFF, "count up");
    pulse(5'h1F);
    check(CCE_CW'(terminal_count), 16'h001F, "all in tc");
    check(CCE_CW'(counter_out), 16'h001F, "tc on pin");
    check(CCE_CW'(armed), '0, "disarmed at tc");
    check(counter_value[3], 16'hFFFE, "tc reload from load");
    $display("test wide done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial
  begin
    for (int i = 0; i < CCE_NUM_CTR; i++)
      load_data[i] = 16'h0100 + CCE_CW'(i);
    repeat (3) @(posedge mclk);
    #1;
    rst = 1'b0;
    t_reset();
    t_arm();
    t_save();
    t_toggle();
    t_step();
    t_tc_disarm();
    t_alt();
    t_gate_src();
    t_retrig();
    t_wide();
    conclude();
  end

  // cuts a hang short
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    conclude();
  end
endmodule
